// File: rtl/bfr_cfg.svh
`ifndef BFR_CFG_SVH
`define BFR_CFG_SVH

// Register byte offsets
`define BFR_OFF_CTRL 8'h00
`define BFR_OFF_FULL_THR 8'h04
`define BFR_OFF_AFULL_THR 8'h08
`define BFR_OFF_AEMPTY_THR 8'h0c
`define BFR_OFF_STATUS 8'h10
`define BFR_OFF_IRQ_STAT 8'h14
`define BFR_OFF_IRQ_CLR 8'h18
`define BFR_OFF_IRQ_EN 8'h1c
`define BFR_OFF_LAST 8'h1c

// Control field layout and reset value
`define BFR_CTRL_W 4
`define BFR_CTRL_FIFO_BIT 2
`define BFR_CTRL_ASYNC_BIT 3
`define BFR_CTRL_RST 4'h4

// Status field layout
`define BFR_STAT_OCC_LSB 16

// Almost-empty threshold reset value and fixed empty threshold
`define BFR_AE_THR_RST 16'h0001
`define BFR_EMPTY_THR 16'h0000

// Interrupt width and bus answers
`define BFR_IRQ_W 6
`define BFR_RESP_OKAY 2'h0
`define BFR_RESP_SLVERR 2'h2

`endif

// File: rtl/bfr_pkg.sv
package bfr_pkg;

  // Port A behaviour on a write cycle
  typedef enum logic [1:0] {
    WR_NORMAL,
    WR_THROUGH,
    WR_READ_FIRST
  } bfr_wmode_t;

  // Bit order of the interrupt status register
  typedef enum int {
    IRQ_EMPTY,
    IRQ_AEMPTY,
    IRQ_AFULL,
    IRQ_FULL,
    IRQ_OVERFLOW,
    IRQ_UNDERFLOW
  } bfr_irq_t;

endpackage

// File: rtl/bfr_rst_sync.sv
`timescale 1ns/100ps
`default_nettype none

module bfr_rst_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Asynchronous requests, active high
  input wire logic [W-1:0] arst,
  // Asserted at once, released on the clock
  output logic [W-1:0] srst
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [1:0] stage_q;
    // Async set, two-stage release so downstream flops never see a mid-edge removal
    always_ff @(posedge sys_clk or negedge rst_n or posedge arst[i]) begin
      if (!rst_n) begin
        stage_q <= 2'h3;
      end else if (arst[i]) begin
        stage_q <= 2'h3;
      end else if (clkEn) begin
        stage_q <= {stage_q[0], 1'b0};
      end
    end
    assign srst[i] = stage_q[1];
  end

endmodule

`default_nettype wire

// File: rtl/bfr_ram.sv
`timescale 1ns/100ps
`default_nettype none

module bfr_ram #(
  parameter int DW = 16,
  parameter int AW = 8
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Port A, read or write
  input wire logic aEn,
  input wire logic aWe,
  input wire logic [AW-1:0] aAddr,
  input wire logic [DW-1:0] aWdata,
  input wire bfr_pkg::bfr_wmode_t wrMode,
  input wire logic aClr,
  input wire logic aArst,
  output logic [DW-1:0] aQ,
  // Port B, read only
  input wire logic bEn,
  input wire logic [AW-1:0] bAddr,
  input wire logic bClr,
  input wire logic bArst,
  output logic [DW-1:0] bQ
);

  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] aOld;

  assign aOld = mem[aAddr];

  // Array write, no reset so it maps to block memory
  always_ff @(posedge sys_clk) begin
    if (clkEn && aEn && aWe) begin
      mem[aAddr] <= aWdata;
    end
  end

  // Port A output latch
  always_ff @(posedge sys_clk or negedge rst_n or posedge aArst) begin
    if (!rst_n) begin
      aQ <= '0;
    end else if (aArst) begin
      aQ <= '0; // R9 R10
    end else if (clkEn) begin
      if (aClr) begin
        aQ <= '0; // R9
      end else if (aEn && aWe) begin
        case (wrMode)
          bfr_pkg::WR_THROUGH: aQ <= aWdata; // R2
          bfr_pkg::WR_READ_FIRST: aQ <= aOld; // R3
          default: aQ <= aQ; // R1
        endcase
      end else if (aEn) begin
        aQ <= aOld;
      end
    end
  end

  // Port B output latch
  always_ff @(posedge sys_clk or negedge rst_n or posedge bArst) begin
    if (!rst_n) begin
      bQ <= '0;
    end else if (bArst) begin
      bQ <= '0; // R9 R10
    end else if (clkEn) begin
      if (bClr) begin
        bQ <= '0; // R9
      end else if (bEn) begin
        bQ <= mem[bAddr];
      end
    end
  end

  a_normal_hold: assert property (@(posedge sys_clk) disable iff (!rst_n || aArst) // R1
    (clkEn && aEn && aWe && !aClr && wrMode == bfr_pkg::WR_NORMAL) |=> aQ == $past(aQ))
    else $error("normal write changed port A output");

  a_through_copy: assert property (@(posedge sys_clk) disable iff (!rst_n || aArst) // R2
    (clkEn && aEn && aWe && !aClr && wrMode == bfr_pkg::WR_THROUGH) |=> aQ == $past(aWdata))
    else $error("write-through did not show written word");

  a_read_first: assert property (@(posedge sys_clk) disable iff (!rst_n || aArst) // R3
    (clkEn && aEn && aWe && !aClr && wrMode == bfr_pkg::WR_READ_FIRST) |=> aQ == $past(aOld))
    else $error("read-before-write did not show old word");

  a_port_clear: assert property (@(posedge sys_clk) disable iff (!rst_n || bArst) // R9
    (clkEn && bClr) |=> (bQ == '0) ##1 ($past(bClr) || $past(bEn) || bQ == $past(bQ)))
    else $error("port B clear not applied or not held");

endmodule

`default_nettype wire

// File: rtl/bfr_fifo_top.sv
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "bfr_cfg.svh"
// Function
// R1 - Normal mode: writes leave port output unchanged
// R2 - Write-through: port output copies incoming write data
// R3 - Read-before-write: port output shows old contents
// R4 - Separate push and pop ports with gates
// R5 - Full flags on push clock, empty on pop
// R6 - Thresholds: full 1..max, others 1..full-1
// R7 - Global clear resets pointers and all flags
// R8 - Rewind resets only read pointer, keeps data
// R9 - Per-port output clear, sync or async
// R10 - Global reset clears both port output latches
// R11 - User drops enables around asynchronous resets
// R12 - Enabled clocks steady one period around reset
// R13 - Global reset acts asynchronously on memory
// R14 - Preload needs global reset disabled or early
// R15 - Strobes act as enables for reset sequencing
// R16 - Clear and rewind are asynchronous inputs
// R17 - Synchronous reset needs no special sequencing
// R18 - Flags follow occupancy across their thresholds

module bfr_fifo_top #(
  parameter int DW = 16,
  parameter int AW = 8
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Push side pins
  input wire logic pushSideClock,
  input wire logic pushClockGate,
  input wire logic pushStrobe,
  input wire logic [DW-1:0] pushData,
  input wire logic [AW-1:0] portAAddr,
  // Pop side pins
  input wire logic popSideClock,
  input wire logic popClockGate,
  input wire logic popStrobe,
  input wire logic [AW-1:0] portBAddr,
  // Reset pins
  input wire logic deviceGlobalResetN,
  input wire logic fifoGlobalClear,
  input wire logic readPointerRewind,
  input wire logic portAOutputClear,
  input wire logic portBOutputClear,
  // Data outputs
  output logic [DW-1:0] portAData,
  output logic [DW-1:0] popData,
  // Flags and interrupt
  output logic fullFlag,
  output logic almostFullFlag,
  output logic almostEmptyFlag,
  output logic emptyFlag,
  output logic irq,
  // AXI4-Lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  localparam int SW = 8 + DW + 2 * AW;
  localparam logic [AW-1:0] THR_MAX = '1;
  localparam logic [AW-1:0] AF_RST = THR_MAX - 1'b1;

  // Occupancy field must fit above the flag bits
  if (DW < 1 || DW > 32 || AW < 2 || AW > 15) begin : g_bad_params
    $error("bfr_fifo_top: DW must be 1..32 and AW 2..15");
  end

  logic [SW-1:0] meta_q, sync_q;
  logic [1:0] clkDly_q;
  logic pushClkS, pushGateS, pushStbS, popClkS, popGateS, popStbS, clrAS, clrBS;
  logic [DW-1:0] pushDataS;
  logic [AW-1:0] aAddrS, bAddrS;
  logic pushTick, popTick, pushReq, popReq, ptrPush, ptrPop, fullNow, fullNext;
  logic gsrS, gclrS, rewindS, clrAArstS, clrBArstS, rdRst;
  logic [AW:0] wrPtr_q, rdPtr_q, occ, occNext;
  logic fullFlag_q, almostFullFlag_q, almostEmptyFlag_q, emptyFlag_q, irq_q;
  logic [`BFR_CTRL_W-1:0] ctrl_q;
  logic [AW-1:0] fullThr_q, afThr_q, aeThr_q;
  logic [`BFR_IRQ_W-1:0] irqStat_q, irqEn_q, irqSet, clrMask;
  logic awHave_q, wHave_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awAddr_q, wrAddr, rdAddr;
  logic [31:0] wData_q, wrWord, rdata_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wrFire, thrBad, fifoEn, asyncClr;

  assign fifoEn = ctrl_q[`BFR_CTRL_FIFO_BIT];
  assign asyncClr = ctrl_q[`BFR_CTRL_ASYNC_BIT];

  // Side pins and port output clears pass two flops; data rides beside its strobe so they stay aligned
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (clkEn) begin
      meta_q <= {pushSideClock, pushClockGate, pushStrobe, popSideClock, popClockGate,
                 popStrobe, portAOutputClear, portBOutputClear, pushData, portAAddr, portBAddr};
      sync_q <= meta_q;
    end
  end

  assign {pushClkS, pushGateS, pushStbS, popClkS, popGateS, popStbS, clrAS, clrBS,
          pushDataS, aAddrS, bAddrS} = sync_q;

  // Rising edges of the sampled side clocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkDly_q <= 2'h0;
    end else if (clkEn) begin
      clkDly_q <= {pushClkS, popClkS};
    end
  end

  assign pushTick = pushClkS & ~clkDly_q[1];
  assign popTick = popClkS & ~clkDly_q[0];
  // Gate and strobe qualify each side clock edge
  assign pushReq = pushTick & pushGateS & pushStbS; // R4
  assign popReq = popTick & popGateS & popStbS; // R4

  // Asynchronous resets: asserted at once, released on sys_clk
  bfr_rst_sync #(
    .W(5)
  ) u_rst_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .arst({~deviceGlobalResetN, fifoGlobalClear, readPointerRewind,
           portAOutputClear & asyncClr, portBOutputClear & asyncClr}), // R13 R16 R9
    .srst({gsrS, gclrS, rewindS, clrAArstS, clrBArstS})
  );

  // Occupancy and refusals
  assign occ = wrPtr_q - rdPtr_q;
  assign fullNow = occ >= {1'b0, fullThr_q};
  assign ptrPush = fifoEn & pushReq & ~fullNow;
  assign ptrPop = fifoEn & popReq & (occ != '0);
  assign occNext = (AW + 1)'(occ + {{AW{1'b0}}, ptrPush} - {{AW{1'b0}}, ptrPop});
  assign fullNext = occNext >= {1'b0, fullThr_q};

  // Write pointer; clear is an async input to the pointer flops
  always_ff @(posedge sys_clk or negedge rst_n or posedge gclrS) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
    end else if (gclrS) begin
      wrPtr_q <= '0; // R7 R16
    end else if (clkEn && ptrPush) begin
      wrPtr_q <= wrPtr_q + 1'b1;
    end
  end

  // Rewind touches only the read side, so stored words can be replayed
  assign rdRst = gclrS | rewindS; // R8 R16
  always_ff @(posedge sys_clk or negedge rst_n or posedge rdRst) begin
    if (!rst_n) begin
      rdPtr_q <= '0;
    end else if (rdRst) begin
      rdPtr_q <= '0; // R7 R8 R16
    end else if (clkEn && ptrPop) begin
      rdPtr_q <= rdPtr_q + 1'b1;
    end
  end

  // Full and almost full move only on push side clock edges
  always_ff @(posedge sys_clk or negedge rst_n or posedge gclrS) begin
    if (!rst_n) begin
      fullFlag_q <= 1'b0;
      almostFullFlag_q <= 1'b0;
    end else if (gclrS) begin
      fullFlag_q <= 1'b0; // R7
      almostFullFlag_q <= 1'b0; // R7
    end else if (clkEn && pushTick) begin
      fullFlag_q <= fullNext; // R5 R18
      almostFullFlag_q <= occNext >= {1'b0, afThr_q}; // R5 R18
    end
  end

  // Empty and almost empty move only on pop side clock edges
  always_ff @(posedge sys_clk or negedge rst_n or posedge gclrS) begin
    if (!rst_n) begin
      emptyFlag_q <= 1'b1;
      almostEmptyFlag_q <= 1'b1;
    end else if (gclrS) begin
      emptyFlag_q <= 1'b1; // R7
      almostEmptyFlag_q <= 1'b1; // R7
    end else if (clkEn && popTick) begin
      emptyFlag_q <= occNext == (AW + 1)'(`BFR_EMPTY_THR); // R5 R6 R18
      almostEmptyFlag_q <= occNext <= {1'b0, aeThr_q}; // R5 R18
    end
  end

  // Memory; in RAM mode the side pins address it directly
  bfr_ram #(
    .DW(DW),
    .AW(AW)
  ) u_ram (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .aEn(fifoEn ? ptrPush : (pushTick & pushGateS)),
    .aWe(fifoEn | pushStbS),
    .aAddr(fifoEn ? wrPtr_q[AW-1:0] : aAddrS),
    .aWdata(pushDataS),
    .wrMode(bfr_pkg::bfr_wmode_t'(ctrl_q[1:0])),
    .aClr(clrAS & ~asyncClr), // R9
    .aArst(gsrS | clrAArstS), // R10 R13
    .aQ(portAData),
    .bEn(fifoEn ? ptrPop : popReq),
    .bAddr(fifoEn ? rdPtr_q[AW-1:0] : bAddrS),
    .bClr(clrBS & ~asyncClr), // R9
    .bArst(gsrS | clrBArstS), // R10 R13
    .bQ(popData)
  );

  // Register readback, also the old value for byte-strobe merging
  function automatic logic [31:0] readReg(input logic [7:0] addr);
    logic [31:0] r;
    r = '0;
    case (addr)
      `BFR_OFF_CTRL: r[`BFR_CTRL_W-1:0] = ctrl_q;
      `BFR_OFF_FULL_THR: r[AW-1:0] = fullThr_q;
      `BFR_OFF_AFULL_THR: r[AW-1:0] = afThr_q;
      `BFR_OFF_AEMPTY_THR: r[AW-1:0] = aeThr_q;
      `BFR_OFF_STATUS: begin
        r[3:0] = {fullFlag_q, almostFullFlag_q, almostEmptyFlag_q, emptyFlag_q};
        r[`BFR_STAT_OCC_LSB +: AW + 1] = occ;
      end
      `BFR_OFF_IRQ_STAT: r[`BFR_IRQ_W-1:0] = irqStat_q;
      `BFR_OFF_IRQ_EN: r[`BFR_IRQ_W-1:0] = irqEn_q;
      default: r = '0;
    endcase
    return r;
  endfunction

  // Write decode and byte-lane merge
  always_comb begin
    wrAddr = {awAddr_q[7:2], 2'h0};
    rdAddr = {s_axi_araddr[7:2], 2'h0};
    wrFire = awHave_q & wHave_q & ~bvalid_q;
    wrWord = readReg(wrAddr);
    for (int i = 0; i < 4; i++) begin
      if (wStrb_q[i]) begin
        wrWord[8*i +: 8] = wData_q[8*i +: 8];
      end
    end
    thrBad = 1'b0;
    if (wrAddr == `BFR_OFF_FULL_THR) begin
      thrBad = (wrWord == 32'h0) || (wrWord > 32'(THR_MAX)); // R6
    end else if (wrAddr == `BFR_OFF_AFULL_THR || wrAddr == `BFR_OFF_AEMPTY_THR) begin
      thrBad = (wrWord == 32'h0) || (wrWord >= 32'(fullThr_q)); // R6
    end
  end

  // Write channel: address and data taken in either order, answer after both
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `BFR_RESP_OKAY;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
    end else if (clkEn) begin
      if (s_axi_awvalid && awready_q) begin
        awAddr_q <= s_axi_awaddr;
        awHave_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHave_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wrFire) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wrAddr > `BFR_OFF_LAST || thrBad) ? `BFR_RESP_SLVERR : `BFR_RESP_OKAY;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `BFR_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= readReg(rdAddr);
        rresp_q <= (rdAddr > `BFR_OFF_LAST) ? `BFR_RESP_SLVERR : `BFR_RESP_OKAY;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Control register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `BFR_CTRL_RST;
    end else if (clkEn && wrFire && wrAddr == `BFR_OFF_CTRL) begin
      ctrl_q <= wrWord[`BFR_CTRL_W-1:0];
    end
  end

  // Thresholds; an out-of-range value is refused and the old one kept
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fullThr_q <= THR_MAX;
      afThr_q <= AF_RST;
      aeThr_q <= AW'(`BFR_AE_THR_RST);
    end else if (clkEn && wrFire && !thrBad) begin
      case (wrAddr)
        `BFR_OFF_FULL_THR: fullThr_q <= wrWord[AW-1:0]; // R6
        `BFR_OFF_AFULL_THR: afThr_q <= wrWord[AW-1:0]; // R6
        `BFR_OFF_AEMPTY_THR: aeThr_q <= wrWord[AW-1:0]; // R6
        default: fullThr_q <= fullThr_q;
      endcase
    end
  end

  // Interrupt events: flag rises, refused push and refused pop
  always_comb begin
    irqSet = '0;
    irqSet[bfr_pkg::IRQ_EMPTY] = popTick & (occNext == '0) & ~emptyFlag_q;
    irqSet[bfr_pkg::IRQ_AEMPTY] = popTick & (occNext <= {1'b0, aeThr_q}) & ~almostEmptyFlag_q;
    irqSet[bfr_pkg::IRQ_AFULL] = pushTick & (occNext >= {1'b0, afThr_q}) & ~almostFullFlag_q;
    irqSet[bfr_pkg::IRQ_FULL] = pushTick & fullNext & ~fullFlag_q;
    irqSet[bfr_pkg::IRQ_OVERFLOW] = fifoEn & pushReq & fullNow;
    irqSet[bfr_pkg::IRQ_UNDERFLOW] = fifoEn & popReq & (occ == '0);
    clrMask = (wrFire && wrAddr == `BFR_OFF_IRQ_CLR) ? wrWord[`BFR_IRQ_W-1:0] : '0;
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_q <= '0;
      irqEn_q <= '0;
      irq_q <= 1'b0;
    end else if (clkEn) begin
      irqStat_q <= (irqStat_q & ~clrMask) | irqSet;
      if (wrFire && wrAddr == `BFR_OFF_IRQ_EN) begin
        irqEn_q <= wrWord[`BFR_IRQ_W-1:0];
      end
      irq_q <= |(irqStat_q & irqEn_q);
    end
  end

  // Outputs straight from flops
  assign fullFlag = fullFlag_q;
  assign almostFullFlag = almostFullFlag_q;
  assign almostEmptyFlag = almostEmptyFlag_q;
  assign emptyFlag = emptyFlag_q;
  assign irq = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  a_full_on_push: assert property (@(posedge sys_clk) disable iff (!rst_n || gclrS) // R5
    (clkEn && pushTick && fullNext) |=> fullFlag_q ##1 (fullFlag_q || pushTick))
    else $error("full flag missed or dropped without push edge");

  a_empty_on_pop: assert property (@(posedge sys_clk) disable iff (!rst_n || gclrS) // R5
    (clkEn && popTick && occNext != '0) |=> !emptyFlag_q)
    else $error("empty flag set while words remain");

  a_aempty_thr: assert property (@(posedge sys_clk) disable iff (!rst_n || gclrS) // R18
    (clkEn && popTick && occNext <= {1'b0, aeThr_q}) |=> almostEmptyFlag_q)
    else $error("almost empty not set at threshold");

  a_gclr_state: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
    gclrS |-> (wrPtr_q == '0 && rdPtr_q == '0 && emptyFlag_q && almostEmptyFlag_q
               && !fullFlag_q && !almostFullFlag_q))
    else $error("global clear left pointers or flags");

  a_rewind_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n || gclrS) // R8
    (rewindS && !ptrPush) |-> (rdPtr_q == '0) ##1 (wrPtr_q == $past(wrPtr_q)))
    else $error("rewind disturbed write side");

  a_global_outs: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    gsrS |-> (portAData == '0 && popData == '0))
    else $error("global reset left output latches");

  a_thr_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
    (clkEn && wrFire && wrAddr == `BFR_OFF_FULL_THR && wrWord == 32'h0)
    |=> fullThr_q == $past(fullThr_q) && s_axi_bresp == `BFR_RESP_SLVERR)
    else $error("zero full threshold accepted");

endmodule

`default_nettype wire

// File: testbench/bfr_fabric_model.sv
`timescale 1ns/100ps
`default_nettype none

module bfr_fabric_model #(
  parameter int DW = 16
) (
  // Clock
  input wire logic sys_clk,
  // Push pins
  output logic pushSideClock,
  output logic pushClockGate,
  output logic pushStrobe,
  output logic [DW-1:0] pushData,
  // Pop pins and completion
  output logic popSideClock,
  output logic popClockGate,
  output logic popStrobe,
  output logic popDone
);
  // Idle with every strobe low so clears and rewinds meet quiet enables
  initial begin
    {pushSideClock, pushClockGate, pushStrobe, popSideClock} = 4'h0;
    {popClockGate, popStrobe, popDone} = 3'h0;
    pushData = '0;
  end

  // One push or pop; pins held steady well around the side clock edges
  task automatic xfer(input logic isPush, input logic [DW-1:0] d);
    if (isPush) begin
      {pushClockGate, pushStrobe} <= 2'h3;
      pushData <= d;
    end else begin
      {popClockGate, popStrobe} <= 2'h3;
    end
    repeat (3) @(posedge sys_clk);
    if (isPush) pushSideClock <= 1'b1;
    else popSideClock <= 1'b1;
    repeat (4) @(posedge sys_clk);
    {pushSideClock, popSideClock} <= 2'h0;
    repeat (4) @(posedge sys_clk);
    // Strobes dropped and data line no longer holds the word
    {pushClockGate, pushStrobe, popClockGate, popStrobe} <= 4'h0;
    pushData <= ~d;
    popDone <= !isPush;
    @(posedge sys_clk);
    popDone <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
endmodule

`default_nettype wire

// File: testbench/block_ram_fifo_with_resets_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "bfr_cfg.svh"

module block_ram_fifo_with_resets_test;
  localparam int DW = 16;
  // Stimulus, all given a value at time zero
  logic sys_clk = 0, rst_n = 0, clkEn = 1, deviceGlobalResetN = 1;
  logic fifoGlobalClear = 0, readPointerRewind = 0, portAOutputClear = 0, portBOutputClear = 0;
  logic [7:0] portAAddr = 0, portBAddr = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  // Observed
  logic pushSideClock, pushClockGate, pushStrobe, popSideClock, popClockGate, popStrobe;
  logic popDone, fullFlag, almostFullFlag, almostEmptyFlag, emptyFlag, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [DW-1:0] pushData, portAData, popData, x;
  logic [DW-1:0] d[4];
  logic [33:0] expQ[$];
  int seed = 99, cycles = 0, miscompares = 0, tests_run = 0;

  bfr_fifo_top #(.DW(DW), .AW(8)) DUT (.sys_clk, .rst_n, .clkEn, .pushSideClock,
    .pushClockGate, .pushStrobe, .pushData, .portAAddr, .popSideClock, .popClockGate,
    .popStrobe, .portBAddr, .deviceGlobalResetN, .fifoGlobalClear, .readPointerRewind,
    .portAOutputClear, .portBOutputClear, .portAData, .popData, .fullFlag, .almostFullFlag,
    .almostEmptyFlag, .emptyFlag, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  bfr_fabric_model #(.DW(DW)) fab (.sys_clk, .pushSideClock, .pushClockGate, .pushStrobe,
    .pushData, .popSideClock, .popClockGate, .popStrobe, .popDone);

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (aw | w) begin
      @(posedge sys_clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "write response");
    @(posedge sys_clk);
  endtask

  // Read: expected answer noted for the monitor
  task automatic axr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    expQ.push_back({er, v});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Reset pins: {clear, rewind, port A clear, port B clear} and global reset level
  task automatic pulse(input logic [3:0] v, input logic g);
    {fifoGlobalClear, readPointerRewind, portAOutputClear, portBOutputClear} <= v;
    deviceGlobalResetN <= g;
    repeat (3) @(posedge sys_clk);
    {fifoGlobalClear, readPointerRewind, portAOutputClear, portBOutputClear} <= 4'h0;
    deviceGlobalResetN <= 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask

  // Oldest note taken whenever a read answer or a pop result appears
  always @(posedge sys_clk) begin
    if ((s_axi_rvalid & s_axi_rready) === 1'b1 || popDone === 1'b1) begin
      if (expQ.size() == 0) chk(0, 1, "unexpected result");
      else chk(popDone ? {18'h0, popData} : {s_axi_rresp, s_axi_rdata}, expQ.pop_front(),
        "result");
    end
  end

  // Hang guard, well above the run's length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      final_report;
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    axr(`BFR_OFF_CTRL, `BFR_CTRL_RST, `BFR_RESP_OKAY);
    axr(`BFR_OFF_FULL_THR, 32'hff, `BFR_RESP_OKAY);
    axr(`BFR_OFF_AFULL_THR, 32'hfe, `BFR_RESP_OKAY);
    axr(`BFR_OFF_AEMPTY_THR, `BFR_AE_THR_RST, `BFR_RESP_OKAY);
    axr(8'h20, 32'h0, `BFR_RESP_SLVERR);
    axw(`BFR_OFF_FULL_THR, 32'h0, `BFR_RESP_SLVERR);
    axw(`BFR_OFF_FULL_THR, 32'h100, `BFR_RESP_SLVERR);
    axw(`BFR_OFF_FULL_THR, 32'h4, `BFR_RESP_OKAY);
    axw(`BFR_OFF_AFULL_THR, 32'h4, `BFR_RESP_SLVERR);
    axw(`BFR_OFF_AFULL_THR, 32'h3, `BFR_RESP_OKAY);
    axw(`BFR_OFF_CTRL, 32'h5, `BFR_RESP_OKAY);
    $display("test registers done");
    // Fill past the full threshold; the fifth push is refused
    for (int i = 0; i < 5; i++) begin
      x = DW'($random(seed));
      if (i < 4) d[i] = x;
      fab.xfer(1'b1, x);
      if (i < 4) chk(portAData, x, "write through");
      chk({fullFlag, almostFullFlag}, {i > 2, i > 1}, "full flags");
    end
    for (int i = 0; i < 4; i++) begin
      expQ.push_back(d[i]);
      fab.xfer(1'b0, '0);
      chk({emptyFlag, almostEmptyFlag}, {i == 3, i > 1}, "empty flags");
    end
    $display("test fill and drain done");
    pulse(4'h4, 1'b1);
    expQ.push_back(d[0]);
    fab.xfer(1'b0, '0);
    expQ.push_back(d[1]);
    fab.xfer(1'b0, '0);
    $display("test rewind done");
    pulse(4'h8, 1'b1);
    chk({emptyFlag, almostEmptyFlag, fullFlag, almostFullFlag}, 4'hc, "clear");
    axw(`BFR_OFF_IRQ_EN, 32'h20, `BFR_RESP_OKAY);
    expQ.push_back(d[1]);
    fab.xfer(1'b0, '0);
    chk(irq, 1'b1, "underflow irq");
    axw(`BFR_OFF_IRQ_CLR, 32'h20, `BFR_RESP_OKAY);
    chk(irq, 1'b0, "irq cleared");
    $display("test clear and underflow done");
    axw(`BFR_OFF_CTRL, 32'h6, `BFR_RESP_OKAY);
    x = DW'($random(seed));
    fab.xfer(1'b1, x);
    chk(portAData, d[0], "read before write");
    axw(`BFR_OFF_CTRL, 32'h4, `BFR_RESP_OKAY);
    fab.xfer(1'b1, ~x);
    chk(portAData, d[0], "normal write");
    $display("test write modes done");
    pulse(4'h1, 1'b1);
    chk({portAData, popData}, {d[0], 16'h0}, "port B clear");
    expQ.push_back(x);
    fab.xfer(1'b0, '0);
    pulse(4'h0, 1'b0);
    chk({portAData, popData}, 32'h0, "global reset");
    axw(`BFR_OFF_CTRL, 32'h1, `BFR_RESP_OKAY);
    fab.xfer(1'b1, x);
    chk(portAData, x, "ram mode");
    $display("test output clears done");
    final_report;
  end
endmodule

`default_nettype wire
